// ### pkg/ptb_pkg.sv
// Constants and types shared by the PWM timer files
`default_nettype none
package ptb_pkg;
    // ************************************************
    // Widths
    // ************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int NCH    = 5;

    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_SKIP    = 8'h04;
    localparam logic [7:0] OFS_PERIOD  = 8'h08;
    localparam logic [7:0] OFS_BUFFER  = 8'h0c;
    localparam logic [7:0] OFS_TEMP    = 8'h10;
    localparam logic [7:0] OFS_GENERAL = 8'h14;
    localparam logic [7:0] OFS_C5IOC   = 8'h18;
    localparam logic [7:0] OFS_C5U     = 8'h1c;
    localparam logic [7:0] OFS_C5V     = 8'h20;
    localparam logic [7:0] OFS_C5W     = 8'h24;
    localparam logic [7:0] OFS_CASC    = 8'h28;
    localparam logic [7:0] OFS_STATUS  = 8'h2c;
    localparam logic [7:0] OFS_CMP0    = 8'h30;
    localparam logic [7:0] OFS_CNT0    = 8'h50;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_CASCADE = 1;
    localparam int CTRL_CPWM    = 2;
    localparam int CTRL_XLOWER  = 4;
    localparam int CTRL_XUPPER  = 5;
    localparam int CTRL_FBSEL   = 6;
    localparam int CTRL_BLDC    = 7;
    localparam int CTRL_CAPEN   = 8;
    localparam int SKIP_EN3A    = 0;
    localparam int SKIP_EN4V    = 1;
    localparam int SKIP_CNT     = 4;
    localparam int C5_U_POS     = 0;
    localparam int C5_V_POS     = 8;
    localparam int C5_W_POS     = 16;

    // ************************************************
    // Reset values and codes
    // ************************************************
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] SKIP_RST   = 32'h0000_0000;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] CMP_RST    = 16'hffff;
    localparam logic [1:0]  XFER_NORMAL   = 2'h0;
    localparam logic [1:0]  XFER_SUPPRESS = 2'h1;
    localparam logic [1:0]  XFER_LINKED   = 2'h2;
    localparam logic [1:0]  IOC_CAP_SEL   = 2'h3;

    typedef logic [CNT_W-1:0] ptb_cnt_type;
endpackage
`default_nettype wire

// ### pkg/ptb_carrier_if.sv
// Carrier crest and trough events passed to the capture units
`default_nettype none
interface ptb_carrier_if;
    logic crest;
    logic trough;
    modport src (output crest, output trough);
    modport snk (input crest, input trough);
endinterface
`default_nettype wire

// ### hdl/ptb_pw_capture.sv
// Channel-5 pulse width counter with carrier-timed capture
`default_nettype none
module ptb_pw_capture (
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    input  wire logic                 pinLevel,
    input  wire logic [4:0]           ioCtrl,
    ptb_carrier_if.snk                carrier,
    output logic [ptb_pkg::CNT_W-1:0] capValue
);
    import ptb_pkg::*;

    ptb_cnt_type widthCnt_q;
    ptb_cnt_type widthCnt_d;
    ptb_cnt_type capValue_q;
    ptb_cnt_type capValue_d;
    logic        capMode;
    logic        measHigh;
    logic        capNow;

    // ************************************************
    // Count while the pin is at the measured level
    // ************************************************
    always_comb begin
        capMode  = (ioCtrl[4:3] == IOC_CAP_SEL) && (ioCtrl[1:0] != 2'h0);
        measHigh = ioCtrl[2];
        capNow   = capMode && ((ioCtrl[0] && carrier.trough) || (ioCtrl[1] && carrier.crest)); // [RULE2] [RULE3]
        widthCnt_d = widthCnt_q;
        capValue_d = capValue_q;
        if (capMode && (pinLevel == measHigh)) begin // [RULE2] [RULE3]
            widthCnt_d = widthCnt_q + 16'h0001;
        end
        if (capNow) begin
            capValue_d = widthCnt_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            widthCnt_q <= 16'h0000;
            capValue_q <= 16'h0000;
        end else begin
            widthCnt_q <= widthCnt_d;
            capValue_q <= capValue_d;
        end
    end

    assign capValue = capValue_q;
endmodule
`default_nettype wire

// ### hdl/ptb_timer.sv
// Complementary PWM timer with buffer transfer control and captures
// Function
// [RULE1] DMA only on compare or capture; none for ch5
// [RULE2] Ch5 low-width codes capture trough, crest, both
// [RULE3] Ch5 high-width codes capture trough, crest, both
// [RULE4] Control 0/1 suppresses buffer-to-temporary transfer
// [RULE5] Control 1/0 transfers only inside enabled period
// [RULE6] Enabled period from ch3A and ch4V skip enables
// [RULE7] Transfer timing depends on buffer write age
// [RULE8] Cascade capture latches both counters at once
// [RULE9] Software keeps feedback select set with brushless
// [RULE10] Control 1/1 behaves as normal transfer
//
// Decided for this implementation: the register addresses and the strobed register port.
`default_nettype none
module ptb_timer (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic [ptb_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [ptb_pkg::DATA_W-1:0] regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic [ptb_pkg::DATA_W-1:0] regRdata,
    input  wire logic [ptb_pkg::NCH-1:0] capPin,
    input  wire logic                  ch5UCapturePin,
    input  wire logic                  ch5VCapturePin,
    input  wire logic                  ch5WCapturePin,
    output logic [ptb_pkg::NCH-1:0]    dmaReq,
    output logic                       pwmOut,
    output logic                       pwmOutN
);
    import ptb_pkg::*;

    // ************************************************
    // State
    // ************************************************
    logic [7:0]  syncA_q, syncB_q, prevPin_q;
    logic [31:0] ctrl_q, ctrl_d, skip_q, skip_d, c5Ioc_q, c5Ioc_d, casc_q, casc_d;
    ptb_cnt_type period_q, period_d, buffer_q, buffer_d, temp_q, temp_d, general_q, general_d;
    ptb_cnt_type cnt_q [NCH];
    ptb_cnt_type cnt_d [NCH];
    ptb_cnt_type cmp_q [NCH];
    ptb_cnt_type cmp_d [NCH];
    logic        up_q, up_d, pwm_q, pwm_d, pwmN_q, pwmN_d, holdLate_q, holdLate_d, enPrev_q;
    logic [2:0]  skip3a_q, skip3a_d, skip4v_q, skip4v_d;
    logic [16:0] age_q, age_d;
    logic [NCH-1:0] dma_q, dma_d, match, capEv;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] capU, capV, capW;
    logic        crest, trough, irq3a, enPeriod, xferOk;
    logic [1:0]  xferCtrl;

    ptb_carrier_if carrierBus ();

    function automatic logic [31:0] pad16(input ptb_cnt_type v);
        pad16 = {16'h0000, v};
    endfunction

    function automatic logic isChanOfs(input logic [7:0] a, input logic [7:0] base, output logic [2:0] idx);
        logic [7:0] off;
        off = a - base;
        idx = off[4:2];
        isChanOfs = (a >= base) && (off[7:5] == 3'h0) && (off[1:0] == 2'h0) && (off[4:2] < 3'h5);
    endfunction

    // ************************************************
    // Pin synchroniser
    // ************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q   <= 8'h00;
            syncB_q   <= 8'h00;
            prevPin_q <= 8'h00;
        end else begin
            syncA_q   <= {ch5WCapturePin, ch5VCapturePin, ch5UCapturePin, capPin};
            syncB_q   <= syncA_q;
            prevPin_q <= syncB_q;
        end
    end

    // ************************************************
    // Carrier, transfer and register next state
    // ************************************************
    always_comb begin
        logic [2:0] ci;
        logic       hitCmp;
        logic       hitCnt;
        logic       early;
        ci     = 3'h0;
        hitCmp = 1'b0;
        hitCnt = 1'b0;
        early  = 1'b0;
        ctrl_d     = ctrl_q;
        skip_d     = skip_q;
        c5Ioc_d    = c5Ioc_q;
        casc_d     = casc_q;
        period_d   = period_q;
        buffer_d   = buffer_q;
        temp_d     = temp_q;
        general_d  = general_q;
        up_d       = up_q;
        pwm_d      = pwm_q;
        holdLate_d = holdLate_q;
        skip3a_d   = skip3a_q;
        skip4v_d   = skip4v_q;
        age_d      = age_q;
        cnt_d      = cnt_q;
        cmp_d      = cmp_q;
        rdata_d    = 32'h0000_0000;
        xferCtrl = {ctrl_q[CTRL_XUPPER], ctrl_q[CTRL_XLOWER]};
        // Carrier events on channel 3
        crest  = ctrl_q[CTRL_RUN] && ctrl_q[CTRL_CPWM] && up_q && (cnt_q[3] == period_q);
        trough = ctrl_q[CTRL_RUN] && ctrl_q[CTRL_CPWM] && !up_q && (cnt_q[3] == 16'h0000);
        for (int i = 0; i < NCH; i++) begin
            match[i] = ctrl_q[CTRL_RUN] && (cnt_q[i] == cmp_q[i]) && !ctrl_q[CTRL_CAPEN + i];
            capEv[i] = ctrl_q[CTRL_CAPEN + i] && syncB_q[i] && !prevPin_q[i];
        end
        irq3a = match[3];
        dma_d = match | capEv; // [RULE1]
        // Counters
        if (ctrl_q[CTRL_RUN]) begin
            for (int i = 0; i < NCH; i++) begin
                if (i != 3 && !(i == 2 && ctrl_q[CTRL_CASCADE])) begin
                    cnt_d[i] = cnt_q[i] + 16'h0001;
                end
            end
            if (ctrl_q[CTRL_CASCADE] && (cnt_q[1] == 16'hffff)) begin
                cnt_d[2] = cnt_q[2] + 16'h0001;
            end
            if (!ctrl_q[CTRL_CPWM]) begin
                cnt_d[3] = (cnt_q[3] == period_q) ? 16'h0000 : cnt_q[3] + 16'h0001;
            end else if (period_q != 16'h0000) begin
                if (crest) begin
                    up_d = 1'b0;
                end else if (trough) begin
                    up_d = 1'b1;
                end
                cnt_d[3] = (crest || (!up_q && !trough)) ? cnt_q[3] - 16'h0001 : cnt_q[3] + 16'h0001;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            if (capEv[i]) begin
                cmp_d[i] = cnt_q[i];
            end
        end
        if (ctrl_q[CTRL_CASCADE] && capEv[1]) begin
            casc_d = {cnt_q[2], cnt_q[1]}; // [RULE8]
        end
        pwm_d = ctrl_q[CTRL_CPWM] && (cnt_q[3] < general_q);
        // Interrupt skipping counters
        if (irq3a) begin
            skip3a_d = (skip3a_q >= skip_q[SKIP_CNT +: 3]) ? 3'h0 : skip3a_q + 3'h1;
        end
        if (trough) begin
            skip4v_d = (skip4v_q >= skip_q[SKIP_CNT +: 3]) ? 3'h0 : skip4v_q + 3'h1;
        end
        enPeriod = (skip_q[SKIP_EN3A] && (skip3a_q == skip_q[SKIP_CNT +: 3]))
                 || (skip_q[SKIP_EN4V] && (skip4v_q == skip_q[SKIP_CNT +: 3])); // [RULE6]
        // Age of the carrier cycle since the ch3 compare A event
        if (irq3a) begin
            age_d = 17'h00000;
        end else if (age_q != 17'h1ffff) begin
            age_d = age_q + 17'h00001;
        end
        early = age_q < {period_q, 1'b0};
        if (enPrev_q && !enPeriod) begin
            holdLate_d = 1'b0;
        end
        unique case (xferCtrl)
            XFER_SUPPRESS: xferOk = 1'b0;                       // [RULE4]
            XFER_LINKED:   xferOk = enPeriod && !holdLate_q;    // [RULE5] [RULE7]
            default:       xferOk = 1'b1;                       // [RULE10]
        endcase
        if (crest && xferOk) begin
            temp_d = buffer_q;
        end
        if (trough) begin
            general_d = temp_q;
        end
        // Register writes
        if (regWr) begin
            unique case (regAddr)
                OFS_CTRL:   ctrl_d   = regWdata;
                OFS_SKIP:   skip_d   = regWdata;
                OFS_PERIOD: period_d = regWdata[15:0];
                OFS_C5IOC:  c5Ioc_d  = regWdata;
                OFS_BUFFER: begin
                    buffer_d = regWdata[15:0];
                    if (xferCtrl == XFER_LINKED && !early && enPeriod) begin
                        holdLate_d = 1'b1; // [RULE7]
                    end
                end
                default: begin
                    if (isChanOfs(regAddr, OFS_CMP0, ci)) begin
                        cmp_d[ci] = regWdata[15:0];
                    end
                end
            endcase
        end
        pwmN_d = ctrl_d[CTRL_CPWM] && !pwm_d;
        // Register reads
        if (regRd) begin
            unique case (regAddr)
                OFS_CTRL:    rdata_d = ctrl_q;
                OFS_SKIP:    rdata_d = skip_q;
                OFS_PERIOD:  rdata_d = pad16(period_q);
                OFS_BUFFER:  rdata_d = pad16(buffer_q);
                OFS_TEMP:    rdata_d = pad16(temp_q);
                OFS_GENERAL: rdata_d = pad16(general_q);
                OFS_C5IOC:   rdata_d = c5Ioc_q;
                OFS_C5U:     rdata_d = pad16(capU);
                OFS_C5V:     rdata_d = pad16(capV);
                OFS_C5W:     rdata_d = pad16(capW);
                OFS_CASC:    rdata_d = casc_q;
                OFS_STATUS:  rdata_d = {24'h000000, skip4v_q, skip3a_q, enPeriod, up_q};
                default: begin
                    hitCmp = isChanOfs(regAddr, OFS_CMP0, ci);
                    if (hitCmp) begin
                        rdata_d = pad16(cmp_q[ci]);
                    end
                    hitCnt = isChanOfs(regAddr, OFS_CNT0, ci);
                    if (hitCnt) begin
                        rdata_d = pad16(cnt_q[ci]);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= CTRL_RST;
            skip_q     <= SKIP_RST;
            c5Ioc_q    <= 32'h0000_0000;
            casc_q     <= 32'h0000_0000;
            period_q   <= PERIOD_RST;
            buffer_q   <= 16'h0000;
            temp_q     <= 16'h0000;
            general_q  <= 16'h0000;
            up_q       <= 1'b1;
            pwm_q      <= 1'b0;
            pwmN_q     <= 1'b0;
            holdLate_q <= 1'b0;
            enPrev_q   <= 1'b0;
            skip3a_q   <= 3'h0;
            skip4v_q   <= 3'h0;
            age_q      <= 17'h1ffff;
            dma_q      <= 5'h00;
            rdata_q    <= 32'h0000_0000;
            for (int i = 0; i < NCH; i++) begin
                cnt_q[i] <= 16'h0000;
                cmp_q[i] <= CMP_RST;
            end
        end else begin
            ctrl_q     <= ctrl_d;
            skip_q     <= skip_d;
            c5Ioc_q    <= c5Ioc_d;
            casc_q     <= casc_d;
            period_q   <= period_d;
            buffer_q   <= buffer_d;
            temp_q     <= temp_d;
            general_q  <= general_d;
            up_q       <= up_d;
            pwm_q      <= pwm_d;
            pwmN_q     <= pwmN_d;
            holdLate_q <= holdLate_d;
            enPrev_q   <= enPeriod;
            skip3a_q   <= skip3a_d;
            skip4v_q   <= skip4v_d;
            age_q      <= age_d;
            dma_q      <= dma_d;
            rdata_q    <= rdata_d;
            cnt_q <= cnt_d;
            cmp_q <= cmp_d;
        end
    end

    // ************************************************
    // Channel-5 capture units
    // ************************************************
    assign carrierBus.crest  = crest;
    assign carrierBus.trough = trough;

    ptb_pw_capture capUnitU (.core_clk(core_clk), .rst_b(rst_b), .pinLevel(syncB_q[5]),
        .ioCtrl(c5Ioc_q[C5_U_POS +: 5]), .carrier(carrierBus), .capValue(capU));
    ptb_pw_capture capUnitV (.core_clk(core_clk), .rst_b(rst_b), .pinLevel(syncB_q[6]),
        .ioCtrl(c5Ioc_q[C5_V_POS +: 5]), .carrier(carrierBus), .capValue(capV));
    ptb_pw_capture capUnitW (.core_clk(core_clk), .rst_b(rst_b), .pinLevel(syncB_q[7]),
        .ioCtrl(c5Ioc_q[C5_W_POS +: 5]), .carrier(carrierBus), .capValue(capW));

    assign regRdata = rdata_q;
    assign dmaReq   = dma_q; // [RULE1]
    assign pwmOut   = pwm_q;
    assign pwmOutN  = pwmN_q;
endmodule
`default_nettype wire

// ### sim/ptb_timer_monitor.sv
// Port checker of the PWM timer
`default_nettype none
module ptb_timer_monitor (
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire logic [ptb_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ptb_pkg::DATA_W-1:0] regWdata,
    input wire logic                       regWr,
    input wire logic                       regRd,
    input wire logic [ptb_pkg::DATA_W-1:0] regRdata,
    input wire logic [ptb_pkg::NCH-1:0]    capPin,
    input wire logic                       ch5UCapturePin,
    input wire logic                       ch5VCapturePin,
    input wire logic                       ch5WCapturePin,
    input wire logic [ptb_pkg::NCH-1:0]    dmaReq,
    input wire logic                       pwmOut,
    input wire logic                       pwmOutN
);
    import ptb_pkg::*;
    // ************************
    // Shadow of control state
    // ************************
    logic [31:0]     ctrlQ, ctrlD;
    logic [3:0]      ageQ, ageD;
    logic [4:0]      pinQ, pinD;
    logic [4:0][5:0] histQ, histD;
    always_comb begin
        ctrlD = ctrlQ;
        ageD = ageQ + {3'h0, ageQ != 4'hf};
        pinD = capPin;
        if (regWr && regAddr == OFS_CTRL) begin
            ctrlD = regWdata;
            ageD = 4'h0;
        end
        for (int i = 0; i < NCH; i++) begin
            histD[i] = {histQ[i][4:0], capPin[i] & ~pinQ[i]};
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlQ <= CTRL_RST;
            ageQ <= 4'h0;
            pinQ <= 5'h0;
            histQ <= '0;
        end else begin
            ctrlQ <= ctrlD;
            ageQ <= ageD;
            pinQ <= pinD;
            histQ <= histD;
        end
    end
    // ************************
    // Assertions
    // ************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    rd_idle_a: assert property (!$past(regRd) |-> regRdata == '0)
        else $error("read data not idle");
    rd_unmapped_a: assert property (regRd && regAddr >= 8'h64 |=> regRdata == '0)
        else $error("unmapped read not zero");
    pwm_pair_a: assert property (ctrlQ[CTRL_CPWM] |-> pwmOutN != pwmOut)
        else $error("outputs not complementary");
    pwm_off_a: assert property (!ctrlQ[CTRL_CPWM] |-> !pwmOutN)
        else $error("inverted output active");
    pwm_idle_a: assert property (ageQ > 4'h1 && !ctrlQ[CTRL_CPWM] |-> !pwmOut)
        else $error("output active outside pwm mode");
    pwm_hold_a: assert property (ageQ > 4'h3 && !ctrlQ[CTRL_RUN] |=> $stable(pwmOut))
        else $error("output moved while stopped");
    for (genvar i = 0; i < NCH; i++) begin : g_cap
        cap_dma_a: assert property ($rose(capPin[i]) && ctrlQ[CTRL_CAPEN + i] |-> ##[2:6] dmaReq[i])
            else $error("capture without dma");
        cap_only_a: assert property (dmaReq[i] && ctrlQ[CTRL_CAPEN + i] && ageQ == 4'hf |-> histQ[i] != '0)
            else $error("dma without capture");
        cap_pulse_a: assert property (dmaReq[i] && ctrlQ[CTRL_CAPEN + i] && ageQ == 4'hf |=> !dmaReq[i])
            else $error("dma longer than a cycle");
    end
endmodule
bind ptb_timer ptb_timer_monitor i_ptb_timer_monitor (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capPin(capPin),
    .ch5UCapturePin(ch5UCapturePin), .ch5VCapturePin(ch5VCapturePin), .ch5WCapturePin(ch5WCapturePin),
    .dmaReq(dmaReq), .pwmOut(pwmOut), .pwmOutN(pwmOutN));
`default_nettype wire

// ### sim/ptb_pin_model.sv
// Pulse sources on the timer capture pins
`default_nettype none
module ptb_pin_model (
    input  wire logic                    core_clk,
    output var logic [ptb_pkg::NCH-1:0] capPin,
    output var logic                     ch5U,
    output var logic                     ch5V,
    output var logic                     ch5W
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        capPin = '0;
        ch5U = 1'b0;
        ch5V = 1'b0;
        ch5W = 1'b0;
    end
    task automatic pulse(input int ch, input int width);
        @(posedge core_clk);
        capPin[ch] <= 1'b1;
        repeat (width) @(posedge core_clk);
        capPin[ch] <= 1'b0;
    endtask
    task automatic level5(input logic u, input logic v, input logic w);
        @(posedge core_clk);
        ch5U <= u;
        ch5V <= v;
        ch5W <= w;
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench of the PWM timer
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("wrong value %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ptb_pkg::*;
    logic              core_clk, rst_b, regWr, regRd, ch5U, ch5V, ch5W, pwmOut, pwmOutN;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata, rdv;
    logic [NCH-1:0]    capPin, dmaReq;
    int                error_cnt = 0;
    int                cmp_count = 0;
    ptb_timer i_ptb_timer (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capPin(capPin), .ch5UCapturePin(ch5U),
        .ch5VCapturePin(ch5V), .ch5WCapturePin(ch5W), .dmaReq(dmaReq), .pwmOut(pwmOut), .pwmOutN(pwmOutN));
    ptb_pin_model i_ptb_pin_model (.core_clk(core_clk), .capPin(capPin), .ch5U(ch5U), .ch5V(ch5V), .ch5W(ch5W));
    // ************************
    // Bus and helper tasks
    // ************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a, rdv);
        `CHK(nm, e, rdv)
    endtask
    task automatic count(input int cyc, output int n[NCH]);
        n = '{default: 0};
        repeat (cyc) begin
            @(negedge core_clk);
            for (int i = 0; i < NCH; i++) begin
                if (dmaReq[i] === 1'b1) n[i]++;
            end
        end
    endtask
    task automatic tally_and_finish;
        $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic poll(input logic [7:0] a, inout logic [15:0] v);
        int k;
        for (k = 0; k < 40; k++) begin
            rd(a, rdv);
            if (rdv[15:0] !== v) break;
        end
        if (k == 40) begin
            error_cnt++;
            $display("wrong value capture exp change got %h", v);
            tally_and_finish;
        end
        v = rdv[15:0];
    endtask
    // ************************
    // Scenarios
    // ************************
    task automatic t_reset;
        chk_rd(OFS_CTRL, CTRL_RST, "ctrl reset");
        chk_rd(OFS_SKIP, SKIP_RST, "skip reset");
        chk_rd(OFS_PERIOD, {16'h0, PERIOD_RST}, "period reset");
        for (int i = 0; i < NCH; i++) begin
            chk_rd(OFS_CMP0 + 8'(4 * i), {16'h0, CMP_RST}, "compare reset");
        end
        chk_rd(8'hfc, 32'h0, "unmapped read");
        `CHK("dma idle", 5'h0, dmaReq)
        $display("test reset done");
    endtask
    task automatic t_compare;
        int n[NCH];
        wr(OFS_PERIOD, 32'h0000_000f);
        for (int i = 0; i < NCH; i++) begin
            if (i != 3) wr(OFS_CMP0 + 8'(4 * i), 32'h0000_0020);
        end
        wr(OFS_CTRL, 32'h0000_0001);
        count(80, n);
        for (int i = 0; i < NCH; i++) begin
            `CHK("compare dma", (i == 3) ? 0 : 1, n[i])
        end
        wr(OFS_CTRL, 32'h0);
        $display("test compare done");
    endtask
    task automatic t_capture;
        int n[NCH];
        wr(OFS_CTRL, 32'h0000_1f01);
        for (int c = 0; c < NCH; c++) begin
            fork
                i_ptb_pin_model.pulse(c, 1 + 3 * c);
                count(20, n);
            join
            for (int i = 0; i < NCH; i++) begin
                `CHK("capture dma", (i == c) ? 1 : 0, n[i])
            end
        end
        $display("test capture done");
    endtask
    task automatic t_cascade;
        logic [31:0] c1, c2;
        wr(OFS_CTRL, 32'h0000_0203);
        i_ptb_pin_model.pulse(1, 2);
        repeat (8) @(posedge core_clk);
        rd(OFS_CMP0 + 8'h04, c1);
        rd(OFS_CNT0 + 8'h08, c2);
        rd(OFS_CASC, rdv);
        `CHK("cascade low", c1[15:0], rdv[15:0])
        `CHK("cascade high", c2[15:0], rdv[31:16])
        $display("test cascade done");
    endtask
    task automatic t_ch5;
        logic [4:0]  cd [6] = '{5'h19, 5'h1a, 5'h1b, 5'h1d, 5'h1e, 5'h1f};
        logic [15:0] v, w;
        logic [31:0] st, vb;
        wr(OFS_PERIOD, 32'h0000_0010);
        wr(OFS_CTRL, 32'h0000_0005);
        foreach (cd[k]) begin
            i_ptb_pin_model.level5(cd[k][2], !cd[k][2], cd[k][2]);
            wr(OFS_C5IOC, {11'h0, cd[k], 3'h0, cd[k], 3'h0, cd[k]});
            repeat (4) @(posedge core_clk);
            rd(OFS_C5U, rdv);
            v = rdv[15:0];
            poll(OFS_C5U, v);
            w = v;
            rd(OFS_STATUS, st);
            rd(OFS_C5V, vb);
            poll(OFS_C5U, v);
            `CHK("ch5 width", (cd[k][1:0] == 2'h3) ? 16'h0010 : 16'h0020, 16'(v - w))
            if (cd[k][1:0] != 2'h3) begin
                `CHK("ch5 carrier edge", cd[k][0], st[0])
            end
            rd(OFS_C5V, rdv);
            `CHK("ch5 other level", vb, rdv)
        end
        $display("test ch5 done");
    endtask
    task automatic t_xfer;
        logic [1:0]  xb [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
        logic [31:0] sk [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h2, 32'h0};
        bit          tx [6] = '{1, 0, 0, 1, 1, 1};
        logic [15:0] gen;
        wr(OFS_CMP0 + 8'h0c, 32'h0000_0008);
        foreach (xb[k]) begin
            wr(OFS_CTRL, 32'h0000_00c5 | {26'h0, xb[k], 4'h0});
            wr(OFS_SKIP, sk[k]);
            wr(OFS_BUFFER, {16'h0, 16'h0100 + 16'(k)});
            repeat (80) @(posedge core_clk);
            if (tx[k]) gen = 16'h0100 + 16'(k);
            rd(OFS_GENERAL, rdv);
            `CHK("general reg", gen, rdv[15:0])
        end
        $display("test transfer done");
    endtask
    task automatic t_late;
        wr(OFS_CMP0 + 8'h0c, 32'h0000_ffff);
        wr(OFS_CTRL, 32'h0000_00e5);
        wr(OFS_SKIP, 32'h0000_0001);
        repeat (40) @(posedge core_clk);
        wr(OFS_BUFFER, 32'h0000_01a5);
        repeat (80) @(posedge core_clk);
        chk_rd(OFS_TEMP, 32'h0000_0105, "late write held");
        $display("test late write done");
    endtask
    // ************************
    // Sequence
    // ************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        $display("wrong value run time exp end got hang");
        tally_and_finish;
    end
    initial begin
        rst_b = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = '0;
        regWdata = '0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset;
        t_compare;
        t_capture;
        t_cascade;
        t_ch5;
        t_xfer;
        t_late;
        wr(OFS_CTRL, 32'h0);
        repeat (8) @(posedge core_clk);
        tally_and_finish;
    end
endmodule
`default_nettype wire
